// ### design/image_fallback_reboot_control.sv
// reboot control: image selection, strike counting, fallback and reprogram
//
// Summary of operation
// - fallback or reprogram pulses an internal reset sparing reboot logic and registers.
// - that reset drives init and done low and erases memory before loading.
// - id mismatch, crc failure and watchdog expiry are all fallback errors.
// - watchdog runs only in master configuration modes.
// - watchdog limit is a 16-bit clock count of at least 0201 until sync.
// - each fallback increments strikes; continue only below the image limit.
// - next mode comes from mode pins or the alternate field per override bit.
// - primary and golden locations from their register pairs; top byte is read opcode.
// - after reaching golden, primary returns only on program pin or power cycle.
// - header lives at address zero and has three strikes.
// - header crc error restarts if restart-on-error set and count below 3.
// - watchdog expiry restarts like crc error, ignoring restart-on-error.
// - header count 3 halts with init and done low.
// - primary errors restart at primary below 3, switch to golden at 3.
// - golden errors restart at golden while count below 6.
// - at 6 restart from zero; later errors restart the image in use, halt at 9.
// - successful fallback keeps strikes; soft reboot uses golden; only program clears.
// - fallback disabled with encryption or slave mode.
// - init pulses low while clearing; done low until the new image loads.
// - switching only in single, dual, quad serial and parallel flash modes.
// - history shifts newest entry into older on each outcome.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "image_fallback_regs.svh"
module image_fallback_reboot_control #(
  parameter int unsigned ERASE_LEN = 16
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        programPin,
  input  wire logic [2:0]  modePins,
  input  wire logic        idErrorIn,
  input  wire logic        crcErrorIn,
  input  wire logic        syncFound,
  input  wire logic        loadDone,
  output      logic        configReset,
  output      logic        initStatus,
  output      logic        donePin,
  output      logic [31:0] flashStart,
  output      logic [2:0]  activeMode,
  output      logic        halted
);
  typedef enum logic [2:0] {
    ST_ERASE,
    ST_LOAD,
    ST_RUN,
    ST_HALT
  } phase_t;

  // pin inputs pass two flip-flops
  logic [1:0] progSync;
  logic [1:0] idSync;
  logic [1:0] crcSync;
  logic [1:0] syncSync;
  logic [1:0] doneSync;
  logic [2:0] modeSync0;
  logic [2:0] modeSync1;
  logic       progLast;

  logic [31:0] ctrl;
  logic [3:0]  modeReg;
  image_fallback_pkg::image_loc_t nextLoc;
  image_fallback_pkg::image_loc_t goldLoc;
  logic [15:0] wdogLimit;
  logic [15:0] wdogCount;
  logic [3:0]  strikes;
  logic [7:0]  eraseCount;
  image_fallback_pkg::image_src_t src;
  phase_t      phase;
  logic        usedGolden;
  logic        reprogSeen;
  image_fallback_pkg::boot_entry_t histNew;
  image_fallback_pkg::boot_entry_t histOld;
  image_fallback_pkg::boot_entry_t entry;
  logic        push;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      progSync  <= 2'h0;
      idSync    <= 2'h0;
      crcSync   <= 2'h0;
      syncSync  <= 2'h0;
      doneSync  <= 2'h0;
      modeSync0 <= 3'h0;
      modeSync1 <= 3'h0;
      progLast  <= 1'b0;
    end else if (ce) begin
      progSync  <= {progSync[0], programPin};
      idSync    <= {idSync[0], idErrorIn};
      crcSync   <= {crcSync[0], crcErrorIn};
      syncSync  <= {syncSync[0], syncFound};
      doneSync  <= {doneSync[0], loadDone};
      modeSync0 <= modePins;
      modeSync1 <= modeSync0;
      progLast  <= progSync[1];
    end
  end

  // program pin pulse (rising edge) is the hard reboot
  wire hardReboot = progSync[1] && !progLast;

  // apb decode
  wire access   = psel && penable;
  wire wrEn     = access && pwrite;
  wire selCtrl  = paddr == `OFS_CTRL;
  wire selMode  = paddr == `OFS_MODE;
  wire selNLo   = paddr == `OFS_NEXT_LO;
  wire selNHi   = paddr == `OFS_NEXT_HI;
  wire selGLo   = paddr == `OFS_GOLD_LO;
  wire selGHi   = paddr == `OFS_GOLD_HI;
  wire selWdog  = paddr == `OFS_WDOG;
  wire selStat  = paddr == `OFS_STATUS;
  wire selHist  = paddr == `OFS_HISTORY;
  wire mapped   = selCtrl | selMode | selNLo | selNHi | selGLo | selGHi |
                  selWdog | selStat | selHist;
  wire reprogCmd = wrEn && selCtrl && pwdata[`CTRL_REPROG];
  wire [15:0] wdogWr = (pwdata[15:0] > `WDOG_MIN) ? pwdata[15:0] : `WDOG_MIN;

  logic [31:0] rdMux;
  assign rdMux = selCtrl ? {30'h0, ctrl[1:0]} :
                 selMode ? {28'h0, modeReg} :
                 selNLo  ? {16'h0, nextLoc.addr[15:0]} :
                 selNHi  ? {16'h0, nextLoc.opcode, nextLoc.addr[23:16]} :
                 selGLo  ? {16'h0, goldLoc.addr[15:0]} :
                 selGHi  ? {16'h0, goldLoc.opcode, goldLoc.addr[23:16]} :
                 selWdog ? {16'h0, wdogLimit} :
                 selStat ? {23'h0, halted, usedGolden, donePin, initStatus, strikes, 1'b0} :
                 selHist ? {20'h0, histOld, histNew} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // register file survives soft reboots; cleared only by reset or program pin
  always_ff @(posedge clk) begin
    if (!rstn || (ce && hardReboot)) begin
      ctrl      <= 32'h1;
      modeReg   <= 4'h0;
      nextLoc   <= '0;
      goldLoc   <= '0;
      wdogLimit <= `WDOG_DEFAULT;
    end else if (ce && wrEn && !pslverr) begin
      if (selCtrl) ctrl <= {30'h0, pwdata[1:0]};
      else if (selMode) modeReg <= pwdata[3:0];
      else if (selNLo) nextLoc.addr[15:0] <= pwdata[15:0];
      else if (selNHi) {nextLoc.opcode, nextLoc.addr[23:16]} <= pwdata[15:0];
      else if (selGLo) goldLoc.addr[15:0] <= pwdata[15:0];
      else if (selGHi) {goldLoc.opcode, goldLoc.addr[23:16]} <= pwdata[15:0];
      else if (selWdog) wdogLimit <= wdogWr;
    end
  end

  // mode selection and capability
  assign activeMode = modeReg[`MODE_OVERRIDE] ? modeReg[2:0] : modeSync1;
  // modes 0..3 are master: serial x1, x2, x4 and parallel flash
  wire masterMode = !activeMode[2];
  wire fallbackOn = masterMode && !ctrl[`CTRL_ENCRYPT];
  wire restartErr = ctrl[`CTRL_RESTART_ERR];

  // watchdog: counts clocks until sync, master modes only, off once golden reached
  wire wdogRun = (phase == ST_LOAD) && masterMode && !usedGolden && !syncSync[1];
  wire wdogExp = wdogRun && (wdogCount >= wdogLimit);
  wire anyErr  = (phase == ST_LOAD) && (idSync[1] || crcSync[1] || wdogExp);
  wire mayRetry = wdogExp || restartErr;

  // strike decision
  logic [3:0] next_strikes;
  assign next_strikes = (strikes >= `STRIKE_HALT) ? `STRIKE_HALT : strikes + 4'h1;
  wire errAct = anyErr && fallbackOn && mayRetry;
  wire haltNow = (phase == ST_LOAD) && anyErr && !(fallbackOn && mayRetry
                 && next_strikes < `STRIKE_HALT);

  image_fallback_pkg::image_src_t next_src;
  always_comb begin
    next_src = src;
    if (next_strikes == `STRIKE_GOLD) next_src = image_fallback_pkg::SRC_HEADER;
    else if (src == image_fallback_pkg::SRC_PRIMARY && (next_strikes == `STRIKE_STEP ||
             next_strikes > `STRIKE_GOLD))
      next_src = image_fallback_pkg::SRC_GOLDEN;
    else if (src == image_fallback_pkg::SRC_HEADER && next_strikes == `STRIKE_STEP)
      next_src = image_fallback_pkg::SRC_HEADER;
  end
  wire stepHalt = src == image_fallback_pkg::SRC_HEADER && next_strikes == `STRIKE_STEP
                  && strikes < `STRIKE_STEP;

  always_comb begin
    entry = '0;
    entry.crcError  = crcSync[1];
    entry.idError   = idSync[1];
    entry.wdogError = wdogExp;
    entry.reprog    = reprogSeen;
    entry.fallback  = usedGolden;
    entry.valid     = 1'b1;
  end
  assign push = ce && ((phase == ST_LOAD && (anyErr || doneSync[1])));

  always_ff @(posedge clk) begin
    if (!rstn || (ce && hardReboot)) begin
      strikes    <= `STRIKE_ZERO;
      src        <= image_fallback_pkg::SRC_HEADER;
      phase      <= ST_ERASE;
      eraseCount <= 8'h0;
      wdogCount  <= 16'h0;
      usedGolden <= 1'b0;
      reprogSeen <= 1'b0;
    end else if (ce) begin
      case (phase)
        ST_ERASE: begin
          wdogCount <= 16'h0;
          if (eraseCount >= ERASE_LEN[7:0] - 8'h1) begin
            phase <= ST_LOAD;
          end else begin
            eraseCount <= eraseCount + 8'h1;
          end
        end
        ST_LOAD: begin
          if (wdogRun) wdogCount <= wdogCount + 16'h1;
          if (haltNow || (errAct && stepHalt)) begin
            if (errAct) strikes <= next_strikes;
            phase <= ST_HALT;
          end else if (errAct) begin
            strikes    <= next_strikes;
            src        <= next_src;
            usedGolden <= usedGolden || next_src == image_fallback_pkg::SRC_GOLDEN;
            phase      <= ST_ERASE;
            eraseCount <= 8'h0;
          end else if (doneSync[1]) begin
            phase <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (reprogCmd) begin
            reprogSeen <= 1'b1;
            // header chains to primary; after fallback stays on golden
            src <= usedGolden ? image_fallback_pkg::SRC_GOLDEN
                              : image_fallback_pkg::SRC_PRIMARY;
            phase      <= ST_ERASE;
            eraseCount <= 8'h0;
          end
        end
        default: begin
          phase <= ST_HALT;
        end
      endcase
    end
  end

  boot_history_store u_history (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .clearAll (hardReboot),
    .push     (push),
    .entryIn  (entry),
    .newest   (histNew),
    .older    (histOld)
  );

  // outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      configReset <= 1'b1;
      initStatus  <= 1'b0;
      donePin     <= 1'b0;
      flashStart  <= 32'h0;
      halted      <= 1'b0;
    end else if (ce) begin
      configReset <= phase == ST_ERASE;
      initStatus  <= phase == ST_LOAD || phase == ST_RUN;
      donePin     <= phase == ST_RUN;
      halted      <= phase == ST_HALT;
      case (src)
        image_fallback_pkg::SRC_PRIMARY: flashStart <= nextLoc;
        image_fallback_pkg::SRC_GOLDEN:  flashStart <= goldLoc;
        default:                         flashStart <= {8'h0, `ADDR_ZERO};
      endcase
    end
  end
endmodule : image_fallback_reboot_control

// ### design/image_fallback_regs.svh
// register offsets, field positions, reset values and counts of the reboot control block
`ifndef IMAGE_FALLBACK_REGS_SVH
`define IMAGE_FALLBACK_REGS_SVH
`define OFS_CTRL        12'h000
`define OFS_MODE        12'h004
`define OFS_NEXT_LO     12'h008
`define OFS_NEXT_HI     12'h00c
`define OFS_GOLD_LO     12'h010
`define OFS_GOLD_HI     12'h014
`define OFS_WDOG        12'h018
`define OFS_STATUS      12'h01c
`define OFS_HISTORY     12'h020
`define CTRL_RESTART_ERR 0
`define CTRL_ENCRYPT     1
`define CTRL_REPROG      2
`define MODE_OVERRIDE    3
`define WDOG_DEFAULT    16'hffff
`define WDOG_MIN        16'h0201
`define STRIKE_STEP     4'h3
`define STRIKE_GOLD     4'h6
`define STRIKE_HALT     4'h9
`define STRIKE_ZERO     4'h0
`define ERASE_CYCLES    8'h10
`define ADDR_ZERO       24'h000000
`endif

// ### design/image_fallback_pkg.sv
// types shared by the reboot control block
package image_fallback_pkg;
  typedef enum logic [2:0] {
    SRC_HEADER,
    SRC_PRIMARY,
    SRC_GOLDEN
  } image_src_t;

  typedef struct packed {
    logic crcError;
    logic idError;
    logic wdogError;
    logic reprog;
    logic fallback;
    logic valid;
  } boot_entry_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
  } image_loc_t;
endpackage : image_fallback_pkg

// ### design/boot_history_store.sv
// two-entry boot history: newest outcome in entry zero, previous shifts to entry one
`timescale 1ns/1ps
module boot_history_store (
  input  wire logic                               clk,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  input  wire logic                               clearAll,
  input  wire logic                               push,
  input  wire image_fallback_pkg::boot_entry_t    entryIn,
  output      image_fallback_pkg::boot_entry_t    newest,
  output      image_fallback_pkg::boot_entry_t    older
);
  always_ff @(posedge clk) begin
    if (!rstn || (ce && clearAll)) begin
      newest <= '0;
      older  <= '0;
    end else if (ce && push) begin
      older  <= newest;
      newest <= entryIn;
    end
  end
endmodule : boot_history_store

// ### test/image_fallback_assertions.sv
// port assertions for the reboot control block
`timescale 1ns/1ps
module image_fallback_assertions #(
  parameter int unsigned ERASE_LEN = 16
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        programPin,
  input wire logic        configReset,
  input wire logic        initStatus,
  input wire logic        donePin,
  input wire logic        halted
);
  logic       rstnQ;
  logic [7:0] eraseCnt;
  // the erase pulse is counted from the first edge after reset, not across the reset itself
  always_ff @(posedge clk) begin
    rstnQ <= rstn;
    if (!rstnQ || !configReset) eraseCnt <= 8'h00;
    else eraseCnt <= eraseCnt + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_erase_pins: assert property (configReset |-> !initStatus && !donePin)
    else $error("init or done high while erasing");
  a_erase_len: assert property ($fell(configReset) |-> eraseCnt == 8'(ERASE_LEN))
    else $error("erase pulse length wrong");
  a_init_rise: assert property ($rose(initStatus) |-> $past(configReset))
    else $error("init rose without erase");
  a_halt_pins: assert property (halted |-> !initStatus && !donePin)
    else $error("init or done high while halted");
  a_halt_sticky: assert property ($fell(halted) |-> $past(programPin))
    else $error("halt left without program pin");
  a_done_run: assert property (donePin |-> initStatus && !configReset && !halted)
    else $error("done high outside run");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("no slave error on unmapped address");
  c_erase: cover property ($fell(configReset));
  c_halt: cover property ($rose(halted));
  c_done: cover property ($rose(donePin));
endmodule : image_fallback_assertions
bind image_fallback_reboot_control image_fallback_assertions #(.ERASE_LEN(ERASE_LEN)) chk_i (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .programPin(programPin), .configReset(configReset),
  .initStatus(initStatus), .donePin(donePin), .halted(halted));

// ### test/flash_loader_model.sv
// loader-side model of the configuration flash
`timescale 1ns/1ps
module flash_loader_model (
  input  wire logic       clk,
  input  wire logic [1:0] kind,
  input  wire logic       initStatus,
  input  wire logic       donePin,
  input  wire logic       configReset,
  input  wire logic       halted,
  output      logic       syncFound = 1'b0,
  output      logic       crcErrorIn = 1'b0,
  output      logic       idErrorIn = 1'b0,
  output      logic       loadDone = 1'b0
);
  logic [5:0] step = 6'h00;
  wire        inLoad = initStatus && !donePin && !configReset && !halted;
  always_ff @(posedge clk) begin
    if (!inLoad) begin
      step <= 6'h00;
      syncFound <= 1'b0;
      crcErrorIn <= 1'b0;
      idErrorIn <= 1'b0;
      loadDone <= 1'b0;
    end else begin
      if (step != 6'h3f) step <= step + 6'h01;
      // sync is decided late so the bench can pick the image kind after the load begins
      if (step == 6'h20 && kind != 2'h3) syncFound <= 1'b1;
      if (step == 6'h28) begin
        crcErrorIn <= kind == 2'd1;
        idErrorIn <= kind == 2'd2;
        loadDone <= kind == 2'd0;
      end
    end
  end
endmodule : flash_loader_model

// ### test/image_fallback_reboot_control_tb.sv
// self-checking bench for the reboot control block
`timescale 1ns/1ps
`include "image_fallback_regs.svh"
module image_fallback_reboot_control_tb;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, programPin = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, flashStart, rd;
  logic [2:0]  modePins = 3'd1, activeMode;
  logic [1:0]  kind = 2'd0;
  logic        pready, pslverr, idErrorIn, crcErrorIn, syncFound, loadDone;
  logic        configReset, initStatus, donePin, halted;
  int          err_count = 0, n_compared = 0;
  always #4 clk = ~clk;
  image_fallback_reboot_control #(.ERASE_LEN(4)) dut (.clk(clk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .programPin(programPin),
    .modePins(modePins), .idErrorIn(idErrorIn), .crcErrorIn(crcErrorIn),
    .syncFound(syncFound), .loadDone(loadDone), .configReset(configReset),
    .initStatus(initStatus), .donePin(donePin), .flashStart(flashStart),
    .activeMode(activeMode), .halted(halted));
  flash_loader_model flash (.clk(clk), .kind(kind), .initStatus(initStatus),
    .donePin(donePin), .configReset(configReset), .halted(halted), .syncFound(syncFound),
    .crcErrorIn(crcErrorIn), .idErrorIn(idErrorIn), .loadDone(loadDone));
  task end_sim;
    begin
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      n_compared++;
      if (seen !== exp) begin
        err_count++;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb
  task strikes(input logic [3:0] e);
    begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk({28'h0, rd[4:1]}, {28'h0, e}, "strikes");
    end
  endtask : strikes
  task wait_erase;
    while (configReset !== 1'b1) @(posedge clk);
  endtask : wait_erase
  task run(input logic [1:0] k);
    int   i;
    logic on, seen;
    begin
      kind <= k;
      on = 1'b0;
      seen = 1'b0;
      for (i = 0; i < 3000; i++) begin
        @(posedge clk);
        if (initStatus === 1'b1 && configReset === 1'b0) on = 1'b1;
        if (on && configReset === 1'b1) seen = 1'b1;
        if (halted === 1'b1 || (k == 2'd0 ? donePin === 1'b1 : seen && initStatus === 1'b1))
          break;
      end
    end
  endtask : run
  localparam logic [31:0] PRIM = 32'h0b123456;
  localparam logic [31:0] GOLD = 32'h6b347890;
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    run(2'd0);
    chk(flashStart, 32'h0, "header start");
    apb(1'b0, `OFS_WDOG, 32'h0);
    chk(rd, 32'h0000ffff, "wdog reset");
    apb(1'b1, `OFS_WDOG, 32'h00000100);
    apb(1'b0, `OFS_WDOG, 32'h0);
    chk(rd, {16'h0, `WDOG_MIN}, "wdog clamp");
    apb(1'b0, 12'h024, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    chk({29'h0, activeMode}, 32'h1, "pin mode");
    apb(1'b1, `OFS_MODE, 32'h0000000a);
    chk({29'h0, activeMode}, 32'h2, "alt mode");
    apb(1'b1, `OFS_NEXT_LO, 32'h00003456);
    apb(1'b1, `OFS_NEXT_HI, 32'h00000b12);
    apb(1'b1, `OFS_GOLD_LO, 32'h00007890);
    apb(1'b1, `OFS_GOLD_HI, 32'h00006b34);
    apb(1'b1, `OFS_CTRL, 32'h5);
    wait_erase;
    run(2'd1);
    chk(flashStart, PRIM, "primary");
    strikes(4'h1);
    apb(1'b1, `OFS_CTRL, 32'h0);
    run(2'h3);
    chk(flashStart, PRIM, "primary retry");
    strikes(4'h2);
    apb(1'b1, `OFS_CTRL, 32'h1);
    run(2'h2);
    chk(flashStart, GOLD, "golden");
    strikes(4'h3);
    run(2'h1);
    chk(flashStart, GOLD, "golden retry");
    strikes(4'h4);
    run(2'd0);
    strikes(4'h4);
    apb(1'b0, `OFS_HISTORY, 32'h0);
    chk(rd, 32'h000009c7, "history");
    apb(1'b1, `OFS_CTRL, 32'h4);
    wait_erase;
    run(2'd0);
    chk(flashStart, GOLD, "soft reboot");
    strikes(4'h4);
    programPin <= 1'b1;
    repeat (6) @(posedge clk);
    programPin <= 1'b0;
    wait_erase;
    chk(flashStart, 32'h0, "hard reboot");
    strikes(4'h0);
    run(2'd1);
    strikes(4'h1);
    run(2'd1);
    run(2'd1);
    chk({29'h0, halted, initStatus, donePin}, 32'h4, "halt pins");
    repeat (100) @(posedge clk);
    strikes(4'h3);
    programPin <= 1'b1;
    repeat (6) @(posedge clk);
    programPin <= 1'b0;
    wait_erase;
    run(2'h0);
    chk({29'h0, halted, initStatus, donePin}, 32'h3, "recovered");
    strikes(4'h0);
    modePins <= 3'h4;
    apb(1'b1, `OFS_CTRL, 32'h5);
    chk({29'h0, activeMode}, 32'h4, "slave mode");
    wait_erase;
    run(2'h1);
    chk({29'h0, halted, initStatus, donePin}, 32'h4, "slave halt");
    strikes(4'h0);
    end_sim;
  end
  initial begin
    #400000;
    err_count++;
    end_sim;
  end
endmodule : image_fallback_reboot_control_tb
